// File: dv/hsic_assertions.sv
// Port checker for the hot swap insertion control block.
module hsic_checker
  import hsic_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic core_clk,
  input wire logic srst,
  input hsic_pkg::hsic_avs_req_s avs_req,
  input hsic_pkg::hsic_avs_rsp_s avs_rsp,
  // Pins and gating.
  input wire logic backend_healthy_n,
  input wire logic pci_rst_n,
  input hsic_pkg::hsic_od_s latch_indicator_led_n,
  input hsic_pkg::hsic_od_s enum_n,
  input hsic_pkg::hsic_od_s local_reset_out_n,
  input wire logic eeprom_load_req,
  input wire logic eeprom_load_done,
  input wire logic cfg_accept,
  input wire logic cfg_retry
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Properties on the core clock.
  // ----------------------------------------------------------------
  // Five cycles of a pin level cover the synchroniser and the output register.
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (srst);
  bus_answer_a: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest) else $error("bus answer late");
  ack_single_a: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("acknowledge held too long");
  od_low_a: assert property (!latch_indicator_led_n.o && !enum_n.o)
    else $error("open drain pin driven high");
  unhealthy_float_a: assert property (backend_healthy_n [*5] |=> !enum_n.oe
    && !local_reset_out_n.oe && !cfg_accept && latch_indicator_led_n.oe)
    else $error("not floated");
  powered_reset_a: assert property ((!backend_healthy_n && !pci_rst_n) [*5]
    |=> local_reset_out_n.oe && !local_reset_out_n.o) else $error("local reset not driven");
  rst_gate_a: assert property ((!pci_rst_n) [*5] |=> !cfg_accept && !eeprom_load_req)
    else $error("active during reset");
  enum_ready_a: assert property (enum_n.oe |-> cfg_accept && !cfg_retry)
    else $error("enum outside ready");
  load_end_a: assert property (eeprom_load_req && eeprom_load_done |=> ##[0:1] !eeprom_load_req)
    else $error("load did not end");
  load_gate_a: assert property (eeprom_load_req |-> cfg_retry && !cfg_accept)
    else $error("config accepted during load");
endmodule : hsic_checker

bind hsic_top hsic_checker u_chk (.core_clk, .srst, .avs_req, .avs_rsp, .backend_healthy_n,
  .pci_rst_n, .latch_indicator_led_n, .enum_n, .local_reset_out_n, .eeprom_load_req,
  .eeprom_load_done, .cfg_accept, .cfg_retry);

// File: dv/hsic_far_model.sv
// Far side model: card loader handshake and backplane pull-ups.
module hsic_far_model
  import hsic_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Loader handshake and its pace.
  input wire logic eeprom_load_req,
  input wire logic slow,
  output logic eeprom_load_done,
  // Open-drain pins and their wire levels.
  input hsic_pkg::hsic_od_s latch_indicator_led_n,
  input hsic_pkg::hsic_od_s enum_n,
  output logic led_wire,
  output logic enum_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r;
  // The loader answers after 2 or 20 cycles; done is a single pulse.
  always_ff @(posedge core_clk) begin
    if (srst || !eeprom_load_req || eeprom_load_done) begin
      cnt_r <= 5'h00;
      eeprom_load_done <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 5'h01;
      eeprom_load_done <= (cnt_r == (slow ? 5'h13 : 5'h01));
    end
  end
  // Pull-ups lift a released line, since the device only ever pulls low.
  assign led_wire = latch_indicator_led_n.oe ? latch_indicator_led_n.o : 1'b1;
  assign enum_wire = enum_n.oe ? enum_n.o : 1'b1;
endmodule : hsic_far_model

// File: dv/tb_top.sv
// Self-checking bench for the hot swap insertion control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hsic_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  hsic_avs_req_s avs_req = '0;
  hsic_avs_rsp_s avs_rsp;
  logic backend_healthy_n = 1'b1;
  logic pci_rst_n = 1'b1;
  logic ejector_switch = 1'b1;
  logic local_reset_in_n = 1'b1;
  logic [NOPT-1:0] option_pins = 4'h6;
  hsic_od_s latch_indicator_led_n, enum_n, local_reset_out_n;
  logic eeprom_load_req, eeprom_load_done, cfg_accept, cfg_retry, burst_option_pin, irq;
  logic slow = 1'b1;
  logic led_wire, enum_wire;
  logic [31:0] rd;
  logic [2:0] flags;
  int err_count = 0;
  int n_checks = 0;
  assign flags = {eeprom_load_req, cfg_retry, cfg_accept};
  always #5 core_clk = ~core_clk;
  hsic_top dut (.core_clk, .srst, .avs_req, .avs_rsp, .backend_healthy_n, .pci_rst_n,
    .ejector_switch, .local_reset_in_n, .option_pins, .latch_indicator_led_n, .enum_n,
    .local_reset_out_n, .eeprom_load_req, .eeprom_load_done, .cfg_accept, .cfg_retry,
    .burst_option_pin, .irq);
  hsic_far_model far (.core_clk, .srst, .eeprom_load_req, .slow, .eeprom_load_done,
    .latch_indicator_led_n, .enum_n, .led_wire, .enum_wire);
  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  // Verdict and end of run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One bus cycle held until waitrequest is seen low; two idle edges let effects land.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_rsp.waitrequest !== 1'b0 && i < 40);
    rd = avs_rsp.readdata;
    avs_req <= '0;
    if (i >= 40) begin
      err_count++;
      final_report();
    end
    repeat (2) @(posedge core_clk);
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic await(input int b);
    int i;
    i = 0;
    while (flags[b] !== 1'b1 && i < 60) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 60) begin
      err_count++;
      final_report();
    end
  endtask : await
  // Pin levels change at an edge, then the synchroniser gets eight edges.
  task automatic pins(input logic h, input logic r, input logic s);
    @(posedge core_clk);
    backend_healthy_n <= h;
    pci_rst_n <= r;
    ejector_switch <= s;
    repeat (8) @(posedge core_clk);
  endtask : pins
  // Bound on the whole run.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    final_report();
  end
  // Insertion, extraction, host hold and removal in one sequence.
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    rdchk(REG_STATUS, 32'h31);
    chk(led_wire, 1'b0);
    chk(local_reset_out_n.oe, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    await(2);
    await(0);
    chk(enum_wire, 1'b0);
    chk(led_wire, 1'b1);
    rdchk(REG_HSCS, 32'h80);
    rdchk(REG_STATUS, 32'h618);
    rdchk(REG_ISTS, 32'h9);
    rdchk(8'h20, 32'h0);
    bus(1'b1, REG_HSCS, 32'h80);
    chk(enum_wire, 1'b1);
    rdchk(REG_HSCS, 32'h0);
    bus(1'b1, REG_HSCS, 32'h08);
    chk(led_wire, 1'b0);
    bus(1'b1, REG_IMSK, 32'h2);
    rdchk(REG_IMSK, 32'h2);
    pins(1'b0, 1'b1, 1'b0);
    chk(enum_wire, 1'b0);
    chk(irq, 1'b1);
    rdchk(REG_HSCS, 32'h48);
    bus(1'b1, REG_HSCS, 32'h0a);
    chk(enum_wire, 1'b1);
    bus(1'b1, REG_IMSK, 32'h0);
    chk(irq, 1'b0);
    bus(1'b1, REG_IMSK, 32'h2);
    chk(irq, 1'b1);
    bus(1'b1, REG_ISTS, 32'h2);
    chk(irq, 1'b0);
    rdchk(REG_ISTS, 32'hd);
    option_pins <= 4'h5;
    pins(1'b0, 1'b0, 1'b1);
    chk({local_reset_out_n.oe, local_reset_out_n.o}, 2'b10);
    chk(cfg_accept, 1'b0);
    rdchk(REG_HSCS, 32'h0);
    pins(1'b0, 1'b1, 1'b1);
    await(1);
    chk(enum_wire, 1'b1);
    rdchk(REG_MISC2, 32'h1);
    bus(1'b1, REG_MISC2, 32'h0);
    await(0);
    chk(enum_wire, 1'b0);
    rdchk(REG_HSCS, 32'h80);
    option_pins <= 4'hc;
    local_reset_in_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    local_reset_in_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(burst_option_pin, 1'b1);
    pins(1'b1, 1'b1, 1'b1);
    chk(led_wire, 1'b0);
    chk({local_reset_out_n.oe, enum_wire}, 2'b01);
    final_report();
  end
endmodule : tb_top

// File: logic/hsic_pkg.sv
// Package for hot swap insertion control: offsets, field positions, states and carriers.
package hsic_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave.
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_HSCS = 8'h00;
  localparam logic [7:0] REG_MISC2 = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ISTS = 8'h0c;
  localparam logic [7:0] REG_IMSK = 8'h10;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int HSCS_ENUM_MASK = 1;
  localparam int HSCS_LED_ON = 3;
  localparam int HSCS_EXTRACT = 6;
  localparam int HSCS_INSERT = 7;
  localparam int MISC2_HOLD = 0;
  localparam int OPT_HOLD = 0;
  localparam int OPT_LOAD = 1;
  localparam int OPT_ENUM = 2;
  localparam int OPT_BURST = 3;
  localparam int EV_INSERT = 0;
  localparam int EV_EXTRACT = 1;
  localparam int EV_LATCH = 2;
  localparam int EV_LOAD = 3;
  localparam int NEV = 4;
  localparam int NOPT = 4;

  // Synchroniser input vector layout.
  localparam int IN_HEALTHY = 0;
  localparam int IN_RST = 1;
  localparam int IN_SW = 2;
  localparam int IN_LRI = 3;
  localparam int IN_OPT = 4;
  localparam int SYNC_W = 8;

  // ----------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------
  // Idle pin levels: unpowered, PCI reset released, latch closed, local reset released.
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h0f;
  localparam logic [NOPT-1:0] OPT_RST = 4'h0;
  localparam logic [NEV-1:0] EV_RST = 4'h0;

  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_LOAD = 4'h2,
    ST_HOLD = 4'h4,
    ST_READY = 4'h8
  } hsic_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } hsic_avs_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } hsic_avs_rsp_s;

  // Open-drain pin: output level and enable.
  typedef struct packed {
    logic o;
    logic oe;
  } hsic_od_s;

endpackage : hsic_pkg

// File: logic/hsic_top.sv
// Hot swap insertion control with Avalon-MM register slave.
// Operation
// - Drive LED low when unhealthy or requested.
// - Float LED pin when it should be dark.
// - Ejector low is open, high closed.
// - Internal reset is healthy-off OR PCI reset.
// - While unhealthy, float all outputs but LED.
// - Powered and PCI reset: drive local reset.
// - Sample option pins on three reset edges.
// - Start EEPROM load on reset exit if enabled.
// - After load set insertion, ENUM, accept config.
// - Host hold option: withhold ENUM, retry config.
// - Clearing host hold releases insertion and ENUM.
// - Host write of flag or mask releases ENUM.
// - ENUM signals insertion or coming removal.
// - LED open-drain output, ejector switch input.
// - Provide hot swap control and status register.
module hsic_top
  import hsic_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Avalon-MM register slave.
  input hsic_pkg::hsic_avs_req_s avs_req,
  output hsic_pkg::hsic_avs_rsp_s avs_rsp,
  // Hot swap pins.
  input wire logic backend_healthy_n,
  input wire logic pci_rst_n,
  input wire logic ejector_switch,
  input wire logic local_reset_in_n,
  input wire logic [hsic_pkg::NOPT-1:0] option_pins,
  output hsic_pkg::hsic_od_s latch_indicator_led_n,
  output hsic_pkg::hsic_od_s enum_n,
  output hsic_pkg::hsic_od_s local_reset_out_n,
  // Configuration loader handshake.
  output logic eeprom_load_req,
  input wire logic eeprom_load_done,
  // Host configuration cycle gating and the burst option pin.
  output logic cfg_accept,
  output logic cfg_retry,
  output logic burst_option_pin,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  // Everything the block remembers lives in this one record, so the reset
  // branch and the next-state process cannot drift apart field by field.
  // The synchroniser stages, the filtered levels and the older copy used
  // for edge detection all share one bit layout, set in the package.
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
    logic [SYNC_W-1:0] prev;
    hsic_state_e st;
    logic [NOPT-1:0] opts;
    logic insertion_flag;
    logic extraction_flag;
    logic led_on_request;
    logic enum_interrupt_mask;
    logic hold;
    logic [NEV-1:0] ists;
    logic [NEV-1:0] imsk;
    hsic_avs_rsp_s rsp;
    hsic_od_s led;
    hsic_od_s en;
    hsic_od_s lro;
    logic ee_req;
    logic acc;
    logic rty;
    logic irq;
  } hsic_regs_s;

  hsic_regs_s q_r;
  hsic_regs_s q_nxt;

  // Decoded conditions and bus qualifiers; all of them are combinational
  // functions of the state register, the bus request and, for ev, eeprom_load_done.
  logic healthy_off;
  logic rst_act;
  logic int_reset;
  logic fall_healthy;
  logic rise_rst;
  logic rise_lri;
  logic sample_opts;
  logic [NOPT-1:0] opts_now;
  logic sw_fall;
  logic sw_edge;
  logic bus_req;
  logic take;
  logic wr_low;
  logic [NEV-1:0] ev;
  logic [31:0] rd_val;

  // ----------------------------------------------------------------
  // Conditions derived from the filtered pin levels.
  // ----------------------------------------------------------------
  // Edges are taken between the filtered level and its copy one cycle
  // older, so each pin change yields exactly one single-cycle pulse.
  // A glitch shorter than one clock period never reaches the filter.
  // Only the filtered copy is ever looked at, never the raw stages.
  assign healthy_off = q_r.filt[IN_HEALTHY];
  assign rst_act = ~q_r.filt[IN_RST];
  assign int_reset = healthy_off | rst_act;
  assign fall_healthy = q_r.prev[IN_HEALTHY] & ~q_r.filt[IN_HEALTHY];
  assign rise_rst = ~q_r.prev[IN_RST] & q_r.filt[IN_RST];
  assign rise_lri = ~q_r.prev[IN_LRI] & q_r.filt[IN_LRI];
  assign sample_opts = fall_healthy | rise_rst | rise_lri;
  assign opts_now = sample_opts ? q_r.filt[IN_OPT +: NOPT] : q_r.opts;
  // Low on the switch means the ejector latch has been opened.
  assign sw_fall = q_r.prev[IN_SW] & ~q_r.filt[IN_SW];
  assign sw_edge = q_r.prev[IN_SW] ^ q_r.filt[IN_SW];

  // A request is taken on the edge where waitrequest is seen low.
  assign bus_req = avs_req.read | avs_req.write;
  assign take = bus_req & ~q_r.rsp.waitrequest;
  assign wr_low = take & avs_req.write & avs_req.byteenable[0];

  // ----------------------------------------------------------------
  // Read multiplexer; unmapped offsets read as zero.
  // ----------------------------------------------------------------
  // Map: 0x00 hot swap control and status, 0x04 misc control two,
  // 0x08 live status (state, switch, healthy, reset, options),
  // 0x0c sticky event status and 0x10 event mask.
  // The mux decodes the address that stands during the wait cycle, so the
  // answer shows the registers as they were one edge before the ack.
  always_comb begin
    rd_val = 32'h0;
    case (avs_req.address)
      REG_HSCS: begin
        rd_val[HSCS_INSERT] = q_r.insertion_flag;
        rd_val[HSCS_EXTRACT] = q_r.extraction_flag;
        rd_val[HSCS_LED_ON] = q_r.led_on_request;
        rd_val[HSCS_ENUM_MASK] = q_r.enum_interrupt_mask;
      end
      REG_MISC2: begin
        rd_val[MISC2_HOLD] = q_r.hold;
      end
      REG_STATUS: begin
        rd_val[3:0] = q_r.st;
        rd_val[4] = q_r.filt[IN_SW];
        rd_val[5] = healthy_off;
        rd_val[6] = rst_act;
        rd_val[11:8] = q_r.opts;
      end
      REG_ISTS: begin
        rd_val[NEV-1:0] = q_r.ists;
      end
      REG_IMSK: begin
        rd_val[NEV-1:0] = q_r.imsk;
      end
      default: begin
        rd_val = 32'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    ev = EV_RST;

    // The next state starts as a copy of the present one; each section
    // below overrides only the fields it owns. Later sections win, which
    // is what gives the internal reset and the hardware sets priority.
    // Three-stage synchroniser; a level counts once stages two and three agree.
    q_nxt.s1 = {option_pins, local_reset_in_n, ejector_switch, pci_rst_n,
                backend_healthy_n};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.filt = (q_r.s2 & q_r.s3) | (q_r.filt & (q_r.s2 | q_r.s3));
    q_nxt.prev = q_r.filt;

    // Option pins are latched only at one of the reset release edges.
    // Between those edges the latched copy holds, whatever the pins do.
    q_nxt.opts = opts_now;

    // Bus handshake: one wait cycle, then a single cycle with wait low.
    // The edge that ends the low cycle is the one where a write lands.
    // A master that keeps its request up gets a fresh answer two edges
    // later, so back to back transfers never see a stale acknowledge.
    q_nxt.rsp.waitrequest = 1'b1;
    if (bus_req && q_r.rsp.waitrequest) begin
      q_nxt.rsp.waitrequest = 1'b0;
      q_nxt.rsp.readdata = avs_req.read ? rd_val : 32'h0;
    end

    // Register writes; W1C bits first, hardware sets below win over them.
    // Only byte lane zero carries bits, so a write without it is ignored
    // but still answered like any other.
    if (wr_low) begin
      case (avs_req.address)
        REG_HSCS: begin
          q_nxt.led_on_request = avs_req.writedata[HSCS_LED_ON];
          q_nxt.enum_interrupt_mask = avs_req.writedata[HSCS_ENUM_MASK];
          // Writing the flag or setting the mask drops the insertion flag.
          if (avs_req.writedata[HSCS_INSERT] || avs_req.writedata[HSCS_ENUM_MASK]) begin
            q_nxt.insertion_flag = 1'b0;
          end
          if (avs_req.writedata[HSCS_EXTRACT]) begin
            q_nxt.extraction_flag = 1'b0;
          end
        end
        REG_MISC2: begin
          q_nxt.hold = avs_req.writedata[MISC2_HOLD];
        end
        REG_ISTS: begin
          q_nxt.ists = q_r.ists & ~avs_req.writedata[NEV-1:0];
        end
        REG_IMSK: begin
          q_nxt.imsk = avs_req.writedata[NEV-1:0];
        end
        default: begin
          q_nxt.imsk = q_r.imsk;
        end
      endcase
    end

    // Power-up sequence. Leaving reset, the block either starts the loader,
    // parks in the hold state for the local processor, or goes straight to
    // ready. Only the ready state lets the host configure the card.
    q_nxt.ee_req = 1'b0;
    case (q_r.st)
      ST_RESET: begin
        if (!int_reset) begin
          q_nxt.hold = opts_now[OPT_HOLD];
          if (opts_now[OPT_LOAD]) begin
            q_nxt.st = ST_LOAD;
            q_nxt.ee_req = 1'b1;
          end else if (opts_now[OPT_HOLD]) begin
            q_nxt.st = ST_HOLD;
          end else begin
            q_nxt.st = ST_READY;
            q_nxt.insertion_flag = 1'b1;
            ev[EV_INSERT] = 1'b1;
          end
        end
      end
      ST_LOAD: begin
        q_nxt.ee_req = 1'b1;
        if (eeprom_load_done) begin
          q_nxt.ee_req = 1'b0;
          ev[EV_LOAD] = 1'b1;
          // The loader may have left the hold option as sampled.
          if (q_nxt.hold) begin
            q_nxt.st = ST_HOLD;
          end else begin
            q_nxt.st = ST_READY;
            q_nxt.insertion_flag = 1'b1;
            ev[EV_INSERT] = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // The local processor ends the hold by clearing the control bit.
        if (!q_nxt.hold) begin
          q_nxt.st = ST_READY;
          q_nxt.insertion_flag = 1'b1;
          ev[EV_INSERT] = 1'b1;
        end
      end
      ST_READY: begin
        // Opening the ejector announces the coming removal.
        if (sw_fall) begin
          q_nxt.extraction_flag = 1'b1;
          ev[EV_EXTRACT] = 1'b1;
        end
      end
      default: begin
        q_nxt.st = ST_RESET;
      end
    endcase
    if (q_r.st != ST_RESET && sw_edge) begin
      ev[EV_LATCH] = 1'b1;
    end

    // Internal reset overrides the sequence and the hot swap bits.
    // Events seen in the same cycle are dropped: the card is not live yet,
    // and a stale latch edge must not raise an interrupt after power-up.
    if (int_reset) begin
      q_nxt.st = ST_RESET;
      q_nxt.insertion_flag = 1'b0;
      q_nxt.extraction_flag = 1'b0;
      q_nxt.led_on_request = 1'b0;
      q_nxt.enum_interrupt_mask = 1'b0;
      q_nxt.ee_req = 1'b0;
      ev = EV_RST;
    end

    // Sticky interrupt status; a new event beats a simultaneous clear.
    // The request is registered from the next masked status, on the same edge
    // as the status itself, so software should clear a cause before it unmasks it.
    q_nxt.ists = q_nxt.ists | ev;
    q_nxt.irq = |(q_nxt.ists & q_nxt.imsk);

    // Config gating follows the next state so the outputs line up.
    // Accept and retry are never high together: ready is neither loading
    // nor held, and in reset both are low.
    q_nxt.acc = (q_nxt.st == ST_READY);
    q_nxt.rty = (q_nxt.st == ST_HOLD) | (q_nxt.st == ST_LOAD);

    // LED sinks current while unpowered or when software asks for it.
    // The internal reset clears led_on_request, so it then sinks only while unpowered; local reset out keeps working and ENUM is released.
    q_nxt.led.o = 1'b0;
    q_nxt.led.oe = healthy_off | q_nxt.led_on_request;

    // ENUM is open drain and withheld while held or masked.
    q_nxt.en.o = 1'b0;
    q_nxt.en.oe = ~healthy_off & (q_nxt.insertion_flag | q_nxt.extraction_flag)
                  & ~q_nxt.enum_interrupt_mask & q_nxt.opts[OPT_ENUM]
                  & (q_nxt.st == ST_READY);

    // Local reset out is floated while the back end is unpowered.
    q_nxt.lro.o = ~rst_act;
    q_nxt.lro.oe = ~healthy_off;
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  // The reset branch loads constants only; the synchroniser starts at the
  // idle level of each pin, so no false edge follows the end of reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q_r.s1 <= SYNC_RST;
      q_r.s2 <= SYNC_RST;
      q_r.s3 <= SYNC_RST;
      q_r.filt <= SYNC_RST;
      q_r.prev <= SYNC_RST;
      q_r.st <= ST_RESET;
      q_r.opts <= OPT_RST;
      q_r.insertion_flag <= 1'b0;
      q_r.extraction_flag <= 1'b0;
      q_r.led_on_request <= 1'b0;
      q_r.enum_interrupt_mask <= 1'b0;
      q_r.hold <= 1'b0;
      q_r.ists <= EV_RST;
      q_r.imsk <= EV_RST;
      q_r.rsp <= '{readdata: 32'h0, waitrequest: 1'b1};
      q_r.led <= '{o: 1'b0, oe: 1'b1};
      q_r.en <= '{o: 1'b0, oe: 1'b0};
      q_r.lro <= '{o: 1'b0, oe: 1'b0};
      q_r.ee_req <= 1'b0;
      q_r.acc <= 1'b0;
      q_r.rty <= 1'b0;
      q_r.irq <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from the state register.
  // ----------------------------------------------------------------
  // Nothing is decoded on the way out, so the pins never glitch while the
  // state moves, at the price of one cycle of latency on every output.
  assign avs_rsp = q_r.rsp;
  assign latch_indicator_led_n = q_r.led;
  assign enum_n = q_r.en;
  assign local_reset_out_n = q_r.lro;
  assign eeprom_load_req = q_r.ee_req;
  assign cfg_accept = q_r.acc;
  assign cfg_retry = q_r.rty;
  assign burst_option_pin = q_r.opts[OPT_BURST];
  assign irq = q_r.irq;

endmodule : hsic_top
